// ==== logic/config_overlay_cfg.svh ====
// Purpose: Constants for the configuration overlay command handler
// Assumes: Taskfile registers arrive as parallel 8-bit ports
// Notes: Offsets, codes and field positions only
`ifndef CONFIG_OVERLAY_CFG_SVH
`define CONFIG_OVERLAY_CFG_SVH
`define CO_OPCODE 8'hB1
`define CO_SUB_RESTORE 8'hC0
`define CO_SUB_FREEZE 8'hC1
`define CO_SUB_IDENTIFY 8'hC2
`define CO_SUB_SET 8'hC3
`define CO_RSN_FROZEN 8'h01
`define CO_RSN_PROTECTED 8'h06
`define CO_RSN_UNSUPPORTED 8'h07
`define CO_RSN_BAD_SUB 8'h08
`define CO_RSN_OTHER 8'hFF
`define CO_MAXLBA_WORD 8'h03
`define CO_SIGNATURE 8'hA5
`define CO_LAST_WORD 8'hFF
`define CO_ERR_ABT 8'h04
`define CO_ST_BSY 8'h80
`define CO_ST_RDY 8'h40
`define CO_ST_DRQ 8'h08
`define CO_ST_ERR 8'h01
`endif

// ==== logic/config_overlay_pkg.sv ====
// Purpose: Types for the configuration overlay command handler
// Assumes: Nothing beyond the constants header
// Notes: Types only
package config_overlay_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DATA_OUT,
    ST_DATA_IN,
    ST_CHECK,
    ST_DONE
  } phase_e;
  typedef logic [15:0] word_t;
endpackage

// ==== logic/config_overlay_word.sv ====
// Purpose: One masked capability word of the identify response
// Assumes: Full capability value is constant
// Notes: Overlay only ever clears bits
`timescale 1ns/10ps
module config_overlay_word #(
  parameter logic [15:0] FULL = 16'hFFFF
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic restore,
  input wire logic load,
  input wire logic [15:0] host_word,
  output logic [15:0] reduced_word
);
  logic [15:0] mask_ff;
  logic [15:0] nxt_mask;

  always_comb begin
    nxt_mask = mask_ff;
    if (restore) begin
      nxt_mask = FULL;
    end else if (load) begin
      nxt_mask = host_word & FULL;
    end
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      mask_ff <= 16'hFFFF;
    end else begin
      mask_ff <= nxt_mask;
    end
  end

  assign reduced_word = mask_ff & FULL;

endmodule // config_overlay_word

// ==== logic/config_overlay_handler.sv ====
// Purpose: Configuration overlay command handler behind the taskfile
// Assumes: One command pulse, data words by strobe, power_on_n for power
// Notes: reset models hardware or software reset, power_on_n is power
`timescale 1ns/10ps
`include "config_overlay_cfg.svh"
module config_overlay_handler #(
  parameter logic [15:0] FULL_W63 = 16'h0007,
  parameter logic [15:0] FULL_W82 = 16'h746B,
  parameter logic [15:0] FULL_W83 = 16'h7F09,
  parameter logic [15:0] FULL_W84 = 16'h6163,
  parameter logic [15:0] FULL_W88 = 16'h007F,
  parameter logic [15:0] FULL_LBA = 16'hFFFF,
  parameter logic SUPPORTED = 1'b1
) (
  input wire logic core_clk,
  input wire logic reset,
  input wire logic power_on_n,
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] feature,
  input wire logic protected_area,
  input wire logic lba_changed,
  input wire logic data_wr,
  input wire logic [15:0] data_wr_word,
  input wire logic data_rd,
  output logic [15:0] data_rd_word,
  output logic [7:0] status,
  output logic [7:0] error,
  output logic [7:0] sector_count,
  output logic [7:0] cyl_high,
  output logic [7:0] cyl_low,
  output logic [15:0] cap_w63,
  output logic [15:0] cap_w82,
  output logic [15:0] cap_w83,
  output logic [15:0] cap_w84,
  output logic [15:0] cap_w88
);
  // ***********************************************
  // Structure content and checksum
  // ***********************************************
  function automatic logic [15:0] full_word(input logic [7:0] idx);
    case (idx)
      8'h00: full_word = 16'h0002;
      8'h01: full_word = FULL_W63;
      8'h02: full_word = FULL_W88;
      8'h03: full_word = FULL_LBA;
      8'h07: full_word = FULL_W82;
      8'h08: full_word = FULL_W83;
      default: full_word = 16'h0000;
    endcase
  endfunction

  function automatic logic [7:0] checksum();
    logic [7:0] sum;
    logic [15:0] cur;
    sum = `CO_SIGNATURE;
    for (int i = 0; i < 255; i++) begin
      cur = full_word(8'(i));
      sum = sum + cur[7:0] + cur[15:8];
    end
    checksum = 8'(8'h00 - sum);
  endfunction

  // ***********************************************
  // Frozen flag on the power domain
  // ***********************************************
  logic frozen_ff;
  logic nxt_frozen;
  logic set_frozen;

  always_comb begin
    nxt_frozen = frozen_ff | set_frozen;
  end

  always_ff @(posedge core_clk or negedge power_on_n) begin
    if (!power_on_n) begin
      frozen_ff <= 1'b0;
    end else begin
      frozen_ff <= nxt_frozen;
    end
  end

  // ***********************************************
  // Command sequencer
  // ***********************************************
  config_overlay_pkg::phase_e phase_ff, nxt_phase;
  logic [7:0] idx_ff, nxt_idx;
  logic [15:0] buf_ff [0:4];
  logic [15:0] nxt_buf [0:4];
  logic [15:0] rd_ff, nxt_rd;
  logic [7:0] st_ff, nxt_st, er_ff, nxt_er;
  logic [7:0] sc_ff, nxt_sc, ch_ff, nxt_ch, cl_ff, nxt_cl;
  logic do_restore, do_load, bad;
  logic [7:0] bad_word;
  logic [15:0] bad_bits;

  always_comb begin
    bad = 1'b0;
    bad_word = 8'h00;
    bad_bits = 16'h0000;
    if (lba_changed && protected_area) begin
      bad = 1'b1;
      bad_word = `CO_MAXLBA_WORD;
    end else if (buf_ff[4] != FULL_LBA) begin
      bad = 1'b1;
      bad_word = `CO_MAXLBA_WORD;
      bad_bits = buf_ff[4] ^ FULL_LBA;
    end
  end

  always_comb begin
    nxt_phase = phase_ff;
    nxt_idx = idx_ff;
    for (int i = 0; i < 5; i++) begin
      nxt_buf[i] = buf_ff[i];
    end
    nxt_rd = rd_ff;
    nxt_st = st_ff;
    nxt_er = er_ff;
    nxt_sc = sc_ff;
    nxt_ch = ch_ff;
    nxt_cl = cl_ff;
    set_frozen = 1'b0;
    do_restore = 1'b0;
    do_load = 1'b0;
    case (phase_ff)
      config_overlay_pkg::ST_IDLE: begin
        if (cmd_valid && cmd_code == `CO_OPCODE) begin
          nxt_er = 8'h00;
          nxt_sc = 8'h00;
          nxt_ch = 8'h00;
          nxt_cl = 8'h00;
          nxt_st = `CO_ST_RDY | `CO_ST_ERR;
          nxt_idx = 8'h00;
          if (!SUPPORTED) begin
            nxt_er = `CO_ERR_ABT;
            nxt_sc = `CO_RSN_UNSUPPORTED;
          end else if (feature < `CO_SUB_RESTORE ||
                       feature > `CO_SUB_SET) begin
            nxt_er = `CO_ERR_ABT;
            nxt_sc = `CO_RSN_BAD_SUB;
          end else if (frozen_ff) begin
            nxt_er = `CO_ERR_ABT;
            nxt_sc = `CO_RSN_FROZEN;
          end else if (feature == `CO_SUB_RESTORE) begin
            if (protected_area) begin
              nxt_er = `CO_ERR_ABT;
              nxt_sc = `CO_RSN_PROTECTED;
              nxt_ch = `CO_MAXLBA_WORD;
            end else begin
              do_restore = 1'b1;
              nxt_st = `CO_ST_RDY;
            end
          end else if (feature == `CO_SUB_FREEZE) begin
            set_frozen = 1'b1;
            nxt_st = `CO_ST_RDY;
          end else if (feature == `CO_SUB_IDENTIFY) begin
            nxt_rd = full_word(8'h00);
            nxt_st = `CO_ST_RDY | `CO_ST_DRQ;
            nxt_phase = config_overlay_pkg::ST_DATA_IN;
          end else begin
            nxt_st = `CO_ST_RDY | `CO_ST_DRQ;
            nxt_phase = config_overlay_pkg::ST_DATA_OUT;
          end
        end
      end
      config_overlay_pkg::ST_DATA_IN: begin
        if (data_rd) begin
          nxt_idx = 8'(idx_ff + 8'h01);
          if (idx_ff == 8'hFE) begin
            nxt_rd = {checksum(), `CO_SIGNATURE};
          end else begin
            nxt_rd = full_word(8'(idx_ff + 8'h01));
          end
          if (idx_ff == `CO_LAST_WORD) begin
            nxt_st = `CO_ST_RDY;
            nxt_phase = config_overlay_pkg::ST_IDLE;
          end
        end
      end
      config_overlay_pkg::ST_DATA_OUT: begin
        if (data_wr) begin
          nxt_idx = 8'(idx_ff + 8'h01);
          case (idx_ff)
            8'h01: nxt_buf[0] = data_wr_word;
            8'h03: nxt_buf[4] = data_wr_word;
            8'h07: nxt_buf[1] = data_wr_word;
            8'h08: nxt_buf[2] = data_wr_word;
            8'h02: nxt_buf[3] = data_wr_word;
            default: begin
            end
          endcase
          if (idx_ff == `CO_LAST_WORD) begin
            nxt_st = `CO_ST_BSY;
            nxt_phase = config_overlay_pkg::ST_CHECK;
          end
        end
      end
      config_overlay_pkg::ST_CHECK: begin
        nxt_phase = config_overlay_pkg::ST_IDLE;
        if (bad) begin
          nxt_st = `CO_ST_RDY | `CO_ST_ERR;
          nxt_er = `CO_ERR_ABT;
          nxt_sc = protected_area ? `CO_RSN_PROTECTED : `CO_RSN_OTHER;
          nxt_ch = bad_word;
          nxt_cl = bad_bits[15:8] | bad_bits[7:0];
        end else begin
          do_load = 1'b1;
          nxt_st = `CO_ST_RDY;
        end
      end
      default: begin
        nxt_phase = config_overlay_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk or posedge reset) begin
    if (reset) begin
      phase_ff <= config_overlay_pkg::ST_IDLE;
      idx_ff <= 8'h00;
      for (int i = 0; i < 5; i++) begin
        buf_ff[i] <= 16'hFFFF;
      end
      rd_ff <= 16'h0000;
      st_ff <= `CO_ST_RDY;
      er_ff <= 8'h00;
      sc_ff <= 8'h00;
      ch_ff <= 8'h00;
      cl_ff <= 8'h00;
    end else begin
      phase_ff <= nxt_phase;
      idx_ff <= nxt_idx;
      for (int i = 0; i < 5; i++) begin
        buf_ff[i] <= nxt_buf[i];
      end
      rd_ff <= nxt_rd;
      st_ff <= nxt_st;
      er_ff <= nxt_er;
      sc_ff <= nxt_sc;
      ch_ff <= nxt_ch;
      cl_ff <= nxt_cl;
    end
  end

  // ***********************************************
  // Reduced identify words, word 84 always loaded with its full value
  // ***********************************************
  config_overlay_word #(.FULL(FULL_W63)) u_w63 (.core_clk(core_clk),
    .reset(reset), .restore(do_restore), .load(do_load),
    .host_word(buf_ff[0]), .reduced_word(cap_w63));
  config_overlay_word #(.FULL(FULL_W82)) u_w82 (.core_clk(core_clk),
    .reset(reset), .restore(do_restore), .load(do_load),
    .host_word(buf_ff[1]), .reduced_word(cap_w82));
  config_overlay_word #(.FULL(FULL_W83)) u_w83 (.core_clk(core_clk),
    .reset(reset), .restore(do_restore), .load(do_load),
    .host_word(buf_ff[2]), .reduced_word(cap_w83));
  config_overlay_word #(.FULL(FULL_W84)) u_w84 (.core_clk(core_clk),
    .reset(reset), .restore(do_restore), .load(do_load),
    .host_word(FULL_W84), .reduced_word(cap_w84));
  config_overlay_word #(.FULL(FULL_W88)) u_w88 (.core_clk(core_clk),
    .reset(reset), .restore(do_restore), .load(do_load),
    .host_word(buf_ff[3]), .reduced_word(cap_w88));

  assign data_rd_word = rd_ff;
  assign status = st_ff;
  assign error = er_ff;
  assign sector_count = sc_ff;
  assign cyl_high = ch_ff;
  assign cyl_low = cl_ff;

  // ***********************************************
  // Checks
  // ***********************************************
  a_frozen_abort: assert property (@(posedge core_clk)
    disable iff (reset) cmd_valid && cmd_code == `CO_OPCODE && frozen_ff &&
    SUPPORTED && feature >= `CO_SUB_RESTORE && feature <= `CO_SUB_SET &&
    phase_ff == config_overlay_pkg::ST_IDLE
    |=> error == `CO_ERR_ABT && sector_count == `CO_RSN_FROZEN)
    else $error("frozen subcommand not aborted");
  a_frozen_sticky: assert property (@(posedge core_clk)
    disable iff (!power_on_n) frozen_ff |=> frozen_ff)
    else $error("frozen flag dropped");
  a_reserved_sub: assert property (@(posedge core_clk)
    disable iff (reset) cmd_valid && cmd_code == `CO_OPCODE && SUPPORTED &&
    feature > `CO_SUB_SET && phase_ff == config_overlay_pkg::ST_IDLE
    |=> sector_count == `CO_RSN_BAD_SUB && status[0])
    else $error("reserved subcommand accepted");
  a_restore_full: assert property (@(posedge core_clk)
    disable iff (reset) do_restore |=> cap_w63 == FULL_W63 &&
    cap_w82 == FULL_W82 && cap_w83 == FULL_W83 && cap_w88 == FULL_W88)
    else $error("restore left reductions");
  a_no_add_bits: assert property (@(posedge core_clk)
    disable iff (reset) (cap_w83 & ~FULL_W83) == 16'h0000)
    else $error("capability beyond full set");
  a_protected_rst: assert property (@(posedge core_clk)
    disable iff (reset) do_restore |-> !protected_area)
    else $error("restore with protected area");
  a_identify_drq: assert property (@(posedge core_clk)
    disable iff (reset)
    phase_ff == config_overlay_pkg::ST_DATA_IN |-> status[3])
    else $error("identify without data request");
  a_set_abort: assert property (@(posedge core_clk)
    disable iff (reset) phase_ff == config_overlay_pkg::ST_CHECK && bad
    |=> error == `CO_ERR_ABT && cyl_high == $past(bad_word))
    else $error("bad set not reported");

endmodule // config_overlay_handler

// ==== sim/config_overlay_host.sv ====
// Purpose: Host side model issuing overlay commands and PIO words
// Assumes: Handler samples its inputs on the rising clock edge
// Notes: Drives at falling edges; idle data shows the inverted last value
`timescale 1ns/10ps
module config_overlay_host (
  input wire logic core_clk,
  output logic cmd_valid,
  output logic [7:0] cmd_code,
  output logic [7:0] feature,
  output logic data_wr,
  output logic [15:0] data_wr_word,
  output logic data_rd,
  input wire logic [15:0] data_rd_word
);
  initial begin
    cmd_valid = 1'b0;
    cmd_code = 8'h00;
    feature = 8'h00;
    data_wr = 1'b0;
    data_wr_word = 16'h0000;
    data_rd = 1'b0;
  end
  // Command register write, one cycle
  task automatic command(input logic [7:0] op, input logic [7:0] sub);
    @(negedge core_clk);
    cmd_code = op;
    feature = sub;
    cmd_valid = 1'b1;
    @(negedge core_clk);
    cmd_valid = 1'b0;
    cmd_code = ~op;
    feature = ~sub;
  endtask
  // PIO data-out, one strobe per word
  task automatic write_block(input config_overlay_pkg::word_t blk [256]);
    for (int i = 0; i < 256; i++) begin
      data_wr_word = blk[i];
      data_wr = 1'b1;
      @(negedge core_clk);
      data_wr = 1'b0;
      data_wr_word = ~blk[i];
      @(negedge core_clk);
    end
  endtask
  // PIO data-in, word taken before each strobe
  task automatic read_block(output config_overlay_pkg::word_t blk [256]);
    for (int i = 0; i < 256; i++) begin
      blk[i] = data_rd_word;
      data_rd = 1'b1;
      @(negedge core_clk);
      data_rd = 1'b0;
      @(negedge core_clk);
    end
  endtask
endmodule // config_overlay_host

// ==== sim/test_config_overlay_handler.sv ====
// Purpose: Self-checking bench for the overlay command handler
// Assumes: Default full capability values
// Notes: Random overlays from a fixed seed
`timescale 1ns/10ps
`include "config_overlay_cfg.svh"
module test_config_overlay_handler;
  localparam logic [15:0] W63 = 16'h0007;
  localparam logic [15:0] W82 = 16'h746B;
  localparam logic [15:0] W83 = 16'h7F09;
  localparam logic [15:0] W84 = 16'h6163;
  localparam logic [15:0] W88 = 16'h007F;
  localparam logic [15:0] LBA = 16'hFFFF;
  logic core_clk, reset, power_on_n, protected_area, lba_changed;
  logic cmd_valid, data_wr, data_rd;
  logic [7:0] cmd_code, feature, status, error, sector_count;
  logic [7:0] cyl_high, cyl_low;
  logic [15:0] data_wr_word, data_rd_word;
  logic [15:0] cap_w63, cap_w82, cap_w83, cap_w84, cap_w88;
  logic [15:0] ov63, ov82, ov83, ov88, e63;
  logic [7:0] st_uns, er_uns, sc_uns;
  logic [7:0] rsv [4] = '{8'h00, 8'hBF, 8'hC4, 8'hFF};
  config_overlay_pkg::word_t blk [256];
  config_overlay_pkg::word_t got [256];
  int fails = 0;
  int checks_done = 0;
  int cycles = 0;
  int seed;
  config_overlay_handler #(.FULL_W63(W63), .FULL_W82(W82),
    .FULL_W83(W83), .FULL_W84(W84), .FULL_W88(W88), .FULL_LBA(LBA),
    .SUPPORTED(1'b1)) uut (.core_clk(core_clk), .reset(reset),
    .power_on_n(power_on_n), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .feature(feature),
    .protected_area(protected_area), .lba_changed(lba_changed),
    .data_wr(data_wr), .data_wr_word(data_wr_word), .data_rd(data_rd),
    .data_rd_word(data_rd_word), .status(status), .error(error),
    .sector_count(sector_count), .cyl_high(cyl_high),
    .cyl_low(cyl_low), .cap_w63(cap_w63), .cap_w82(cap_w82),
    .cap_w83(cap_w83), .cap_w84(cap_w84), .cap_w88(cap_w88));
  config_overlay_host host (.core_clk(core_clk), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .feature(feature), .data_wr(data_wr),
    .data_wr_word(data_wr_word), .data_rd(data_rd),
    .data_rd_word(data_rd_word));
  // Second handler built without overlay support
  config_overlay_handler #(.SUPPORTED(1'b0)) uut_uns (.core_clk(core_clk),
    .reset(reset), .power_on_n(power_on_n), .cmd_valid(cmd_valid),
    .cmd_code(cmd_code), .feature(feature),
    .protected_area(protected_area), .lba_changed(lba_changed),
    .data_wr(data_wr), .data_wr_word(data_wr_word), .data_rd(data_rd),
    .data_rd_word(), .status(st_uns), .error(er_uns),
    .sector_count(sc_uns), .cyl_high(), .cyl_low(), .cap_w63(),
    .cap_w82(), .cap_w83(), .cap_w84(), .cap_w88());
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      stop_test();
    end
  end
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [15:0] cut(logic [15:0] f, logic [15:0] o);
    return f & o;
  endfunction
  function automatic logic [7:0] bsum(config_overlay_pkg::word_t w [256]);
    logic [7:0] s = 8'h00;
    for (int i = 0; i < 256; i++)
      s = s + w[i][7:0] + w[i][15:8];
    return s;
  endfunction
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checks_done++;
    if (g !== e) begin
      fails++;
      $display("ERROR %0t got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_abort(input logic [7:0] why);
    chk({8'h00, status}, {8'h00, `CO_ST_RDY | `CO_ST_ERR});
    chk({8'h00, error}, {8'h00, `CO_ERR_ABT});
    chk({8'h00, sector_count}, {8'h00, why});
  endtask
  task automatic fill(input logic [15:0] lba);
    for (int i = 0; i < 256; i++)
      blk[i] = 16'hFFFF;
    blk[1] = ov63;
    blk[2] = ov88;
    blk[3] = lba;
    blk[7] = ov82;
    blk[8] = ov83;
    blk[255] = {8'h00, `CO_SIGNATURE};
    blk[255][15:8] = -bsum(blk);
  endtask
  task automatic run(input logic [7:0] sub);
    host.command(`CO_OPCODE, sub);
    if (status === 8'h48 && sub == `CO_SUB_IDENTIFY)
      host.read_block(got);
    if (status === 8'h48 && sub == `CO_SUB_SET)
      host.write_block(blk);
    for (int n = 0; n < 40 && (status & 8'h88) !== 8'h00; n++)
      @(negedge core_clk);
  endtask
  task automatic stop_test();
    $display("Checks %0d errors %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    reset = 1'b1;
    power_on_n = 1'b0;
    protected_area = 1'b0;
    lba_changed = 1'b0;
    seed = 32'hEC31898F;
    repeat (4) @(negedge core_clk);
    reset = 1'b0;
    power_on_n = 1'b1;
    @(negedge core_clk);
    chk({8'h00, status}, 16'h0040);
    chk(cap_w88, W88);
    host.command(8'hEC, `CO_SUB_IDENTIFY);
    repeat (2) @(negedge core_clk);
    chk({8'h00, status}, 16'h0040);
    rsv[0] = 8'($random(seed)) | 8'h04;
    for (int i = 0; i < 4; i++) begin
      run(rsv[i]);
      chk_abort(`CO_RSN_BAD_SUB);
    end
    chk({st_uns, er_uns}, {`CO_ST_RDY | `CO_ST_ERR, `CO_ERR_ABT});
    chk({8'h00, sc_uns}, {8'h00, `CO_RSN_UNSUPPORTED});
    for (int k = 0; k < 3; k++) begin
      ov63 = 16'($random(seed));
      ov82 = 16'($random(seed));
      ov83 = 16'($random(seed));
      ov88 = 16'($random(seed));
      fill(LBA);
      run(`CO_SUB_SET);
      chk({8'h00, status}, 16'h0040);
      chk(cap_w63, cut(W63, ov63));
      chk(cap_w82, cut(W82, ov82));
      chk(cap_w83, cut(W83, ov83));
      chk(cap_w84, W84);
      chk(cap_w88, cut(W88, ov88));
      run(`CO_SUB_IDENTIFY);
      chk({8'h00, status}, 16'h0040);
      chk({8'h00, bsum(got)}, 16'h0000);
      chk({8'h00, got[255][7:0]}, {8'h00, `CO_SIGNATURE});
      chk(got[1], W63);
      chk(got[7], W82);
      chk(got[8], W83);
      chk(got[2], W88);
    end
    e63 = cut(W63, ov63);
    ov63 = 16'h0000;
    fill(~LBA);
    lba_changed = 1'b1;
    run(`CO_SUB_SET);
    chk_abort(`CO_RSN_OTHER);
    chk(cap_w63, e63);
    protected_area = 1'b1;
    run(`CO_SUB_SET);
    chk_abort(`CO_RSN_PROTECTED);
    chk({8'h00, cyl_high}, {8'h00, `CO_MAXLBA_WORD});
    lba_changed = 1'b0;
    run(`CO_SUB_RESTORE);
    chk_abort(`CO_RSN_PROTECTED);
    chk({8'h00, cyl_high}, {8'h00, `CO_MAXLBA_WORD});
    chk(cap_w63, e63);
    protected_area = 1'b0;
    run(`CO_SUB_RESTORE);
    chk({8'h00, status}, 16'h0040);
    chk(cap_w63, W63);
    chk(cap_w82, W82);
    chk(cap_w83, W83);
    chk(cap_w88, W88);
    fill(LBA);
    run(`CO_SUB_FREEZE);
    chk({8'h00, status}, 16'h0040);
    for (int s = 0; s < 4; s++) begin
      run(8'hC0 + 8'(s));
      chk_abort(`CO_RSN_FROZEN);
    end
    reset = 1'b1;
    repeat (2) @(negedge core_clk);
    reset = 1'b0;
    run(`CO_SUB_RESTORE);
    chk_abort(`CO_RSN_FROZEN);
    reset = 1'b1;
    power_on_n = 1'b0;
    repeat (2) @(negedge core_clk);
    reset = 1'b0;
    power_on_n = 1'b1;
    run(`CO_SUB_RESTORE);
    chk({8'h00, status}, 16'h0040);
    stop_test();
  end
endmodule // test_config_overlay_handler
